// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none

`include "tlpic_defs.svh"

module testbench;
  logic mclk, rst, hwStandby, cyc, stb, wbWe, nmiPin, iMask, uiMask, accept;
  logic ack, intReq, wakeReq, excTaken;
  logic [3:0] sel;
  logic [5:0] pinReqN;
  logic [7:0] adr, intVec, excVec, q, v;
  logic [29:0] intSrc, dmaSteer;
  logic [31:0] datI, datO;
  int bad_count, comparisons, i;
  localparam logic [7:0] OFS [6] = '{`TLPIC_OFS_SENSE, `TLPIC_OFS_ENABLE, `TLPIC_OFS_PRIO1,
    `TLPIC_OFS_PRIO2, `TLPIC_OFS_FLAGS, 8'h20};

  tlpic_ctrl i_dut (.mclk(mclk), .rst(rst), .hwStandby(hwStandby), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .nmiPin(nmiPin), .pinReqN(pinReqN), .intSrc(intSrc),
    .dmaSteer(dmaSteer), .iMask(iMask), .uiMask(uiMask), .excTaken(excTaken),
    .excVec(excVec), .intReq(intReq), .intVec(intVec), .wakeReq(wakeReq));
  tlpic_cpu_model i_cpu (.mclk(mclk), .rst(rst), .accept(accept), .intReq(intReq),
    .intVec(intVec), .excTaken(excTaken), .excVec(excVec));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  function automatic logic [7:0] pinVec(input int n);
    return 8'(`TLPIC_VEC_PIN0 + n);
  endfunction

  function automatic logic [7:0] srcVec(input int k);
    int g;
    g = (k < 2) ? 20 : (k < 5) ? 22 : (k < 8) ? 23 : (k < 11) ? 24 : (k < 14) ? 25 :
      (k < 17) ? 26 : (k < 21) ? 27 : 31;
    return 8'(k + g);
  endfunction

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // Entered just after a rising edge; the request holds until ack is seen high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= we;
    adr <= a;
    sel <= 4'h1;
    datI <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = datO[7:0];
    if (ack !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t no bus acknowledge", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic rstChk();
    rd(`TLPIC_OFS_SYSCTL, `TLPIC_RST_SYSCTL);
    for (int k = 0; k < 6; k++) begin
      rd(OFS[k], 8'h00);
    end
  endtask

  task automatic expReq(input logic [7:0] e);
    int n;
    n = 0;
    repeat (8) @(negedge mclk);
    while (intReq !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk((intReq === 1'b1) ? intVec : 8'hff, e);
    @(posedge mclk);
  endtask

  task automatic lvl(ref logic s, input logic e);
    repeat (12) @(negedge mclk);
    chk({7'h0, s}, {7'h0, e});
    @(posedge mclk);
  endtask

  initial begin
    idle(20000);
    bad_count++;
    wrap_up();
  end

  initial begin
    {rst, hwStandby, cyc, stb, wbWe, iMask, uiMask, accept} = 8'h80;
    nmiPin = 1'b1;
    pinReqN = 6'h3f;
    {sel, adr, datI} = '0;
    intSrc = '0;
    dmaSteer = '0;
    {bad_count, comparisons, q, v} = '0;
    i = $urandom(26);
    idle(2);
    rst <= 1'b0;
    idle(1);
    rstChk();
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wb(1'b1, OFS[k], v);
      rd(OFS[k], v);
    end
    hwStandby <= 1'b1;
    idle(1);
    hwStandby <= 1'b0;
    idle(1);
    rstChk();
    wb(1'b1, OFS[4], 8'hff);
    rd(OFS[4], 8'h00);
    for (int n = 0; n < 6; n++) begin
      wb(1'b1, OFS[1], 8'(1 << n));
      pinReqN[n] <= 1'b0;
      expReq(pinVec(n));
      pinReqN[n] <= 1'b1;
      idle(6);
      rd(OFS[4], 8'(1 << n));
      wb(1'b1, OFS[4], 8'hff);
      rd(OFS[4], 8'(1 << n));
      wb(1'b1, OFS[4], 8'h00);
      lvl(intReq, 1'b0);
    end
    wb(1'b1, OFS[1], 8'h00);
    pinReqN[3] <= 1'b0;
    lvl(intReq, 1'b0);
    iMask <= 1'b1;
    wb(1'b1, OFS[1], 8'h3f);
    lvl(wakeReq, 1'b0);
    pinReqN[0] <= 1'b0;
    lvl(wakeReq, 1'b1);
    lvl(intReq, 1'b0);
    pinReqN <= 6'h3f;
    idle(6);
    rd(OFS[4], 8'h09);
    wb(1'b1, OFS[4], 8'h00);
    wb(1'b1, OFS[1], 8'h00);
    uiMask <= 1'b1;
    nmiPin <= 1'b0;
    expReq(`TLPIC_VEC_NMI);
    accept <= 1'b1;
    lvl(intReq, 1'b0);
    accept <= 1'b0;
    wb(1'b1, `TLPIC_OFS_SYSCTL, 8'h0f);
    nmiPin <= 1'b1;
    expReq(`TLPIC_VEC_NMI);
    accept <= 1'b1;
    lvl(intReq, 1'b0);
    {accept, iMask, uiMask} <= 3'h0;
    wb(1'b1, OFS[0], 8'h01);
    wb(1'b1, OFS[1], 8'h01);
    pinReqN[0] <= 1'b0;
    expReq(pinVec(0));
    accept <= 1'b1;
    lvl(intReq, 1'b0);
    rd(OFS[4], 8'h00);
    accept <= 1'b0;
    pinReqN[0] <= 1'b1;
    idle(6);
    wb(1'b1, OFS[0], 8'h00);
    for (int k = 0; k < 4; k++) begin
      i = $urandom_range(28);
      intSrc <= (30'h1 << i) | (30'h1 << 29);
      wb(1'b1, OFS[3], 8'h11);
      expReq(srcVec(i));
      wb(1'b1, OFS[3], 8'h02);
      expReq(8'd60);
      wb(1'b1, OFS[3], 8'h00);
    end
    intSrc <= 30'h5;
    wb(1'b1, OFS[2], 8'h04);
    expReq(srcVec(2));
    wb(1'b1, OFS[2], 8'h10);
    wb(1'b1, OFS[1], 8'h21);
    pinReqN <= 6'h1e;
    expReq(pinVec(5));
    pinReqN <= 6'h3f;
    wb(1'b1, OFS[1], 8'h00);
    idle(6);
    rd(OFS[4], 8'h21);
    wb(1'b1, OFS[4], 8'h00);
    intSrc <= (30'h1 << 29) | 30'h1;
    wb(1'b1, OFS[3], 8'h02);
    wb(1'b1, `TLPIC_OFS_SYSCTL, 8'h03);
    iMask <= 1'b1;
    expReq(8'd60);
    uiMask <= 1'b1;
    lvl(intReq, 1'b0);
    wb(1'b1, `TLPIC_OFS_SYSCTL, 8'h0b);
    uiMask <= 1'b0;
    lvl(intReq, 1'b0);
    iMask <= 1'b0;
    dmaSteer <= 30'h1 << 29;
    expReq(srcVec(0));
    wrap_up();
  end
endmodule
`default_nettype wire

// File: tlpic_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module tlpic_cpu_model (
  input wire logic mclk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic accept, // Starts exceptions while high.
  input wire logic intReq, // Request from the controller.
  input wire logic [7:0] intVec, // Winning vector.
  output logic excTaken, // One-cycle exception start.
  output logic [7:0] excVec // Vector being handled.
);
  logic [2:0] hold;
  logic take;
  assign take = accept && intReq && hold == 3'h0;
  // A gap after each exception lets the cleared request settle first.
  always_ff @(posedge mclk) begin
    if (rst) begin
      excTaken <= 1'b0;
      excVec <= 8'h00;
      hold <= 3'h0;
    end else begin
      excTaken <= take;
      excVec <= take ? intVec : ~excVec;
      hold <= take ? 3'h7 : hold - {2'h0, hold != 3'h0};
    end
  end
endmodule
`default_nettype wire

// File: tlpic_ctrl.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

`include "tlpic_defs.svh"

// How it works
// - First priority upper bits: pin0, pin1, pins2-3, pins4-5 levels.
// - First priority lower bits: watchdog/refresh, timer channels 0, 1, 2.
// - Second priority: timer 3, 4, DMA, serial 0, 1, A/D.
// - Priority bit one is favoured level; zero is default level.
// - Second priority bits 4 and 0 are storage only.
// - Second priority clears on reset and hardware standby.
// - Flag bits report pins 5-0; bits 7-6 read zero.
// - Flag cleared by writing zero after reading one; ones never set.
// - Exception clears flag: level mode if pin high, edge mode always.
// - Flag sets while pin low (level) or on falling edge (edge).
// - Flags, enables, sense select clear on reset and standby.
// - Enable bits 5-0 gate pin requests; bits 7-6 storage only.
// - Sense bit zero low level, one falling edge; 7-6 storage.
// - Nonmaskable request ignores masks, chosen edge, vector 7.
// - Pins 0-5 use vectors 12-17; vectors are four bytes apart.
// - Pin detection is independent of pin direction.
// - Only nonmaskable and pins 0-2 raise wake-up.
// - Requests steered to DMA are not forwarded nor masked.
// - Same level: smaller vector number wins; reset gives default order.
// - Thirty internal sources arrive already gated by their modules.
// - User bit enable one: global mask blocks all but nonmaskable.
// - User bit enable zero: level one needs both masks set to block.
// - Edge select zero is falling edge, one is rising edge.
module tlpic_ctrl
  import tlpic_pkg::*;
#(
  parameter int NUM_INT = `TLPIC_NINT
) (
  input wire logic mclk, // System clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic hwStandby, // Hardware standby, clears registers.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic nmiPin, // Nonmaskable request pin.
  input wire logic [5:0] pinReqN, // Active-low request pins.
  input wire logic [29:0] intSrc, // Internal requests, module-gated.
  input wire logic [29:0] dmaSteer, // Source is routed to the DMA unit.
  input wire logic iMask, // Global mask bit of the CPU.
  input wire logic uiMask, // User mask bit of the CPU.
  input wire logic excTaken, // CPU starts exception handling.
  input wire logic [7:0] excVec, // Vector being handled.
  output logic intReq, // Request to the CPU.
  output logic [7:0] intVec, // Winning vector number.
  output logic wakeReq // Wake-up from software standby.
);

  if (NUM_INT != 30) begin : g_chk
    $error("tlpic_ctrl: the vector table holds exactly 30 sources");
  end

  function automatic tlpic_rsel_t regSel(input logic [7:0] adr);
    if (adr == `TLPIC_OFS_SYSCTL) begin
      return TLPIC_RS_SYS;
    end else if (adr == `TLPIC_OFS_SENSE) begin
      return TLPIC_RS_SENSE;
    end else if (adr == `TLPIC_OFS_ENABLE) begin
      return TLPIC_RS_EN;
    end else if (adr == `TLPIC_OFS_FLAGS) begin
      return TLPIC_RS_FLAG;
    end else if (adr == `TLPIC_OFS_PRIO1) begin
      return TLPIC_RS_PRIO1;
    end else if (adr == `TLPIC_OFS_PRIO2) begin
      return TLPIC_RS_PRIO2;
    end else begin
      return TLPIC_RS_NONE;
    end
  endfunction

  // Vector number of internal source i, in table order.
  function automatic logic [7:0] intVecOf(input int i);
    int c;
    int k;
    c = (i - 2) / 3;
    k = (i - 2) % 3;
    if (i < 2) begin
      return `TLPIC_VEC_WDT + 8'(i);
    end else if (i < 17) begin
      return `TLPIC_VEC_TMR0 + 8'(4 * c + k);
    end else if (i < 21) begin
      return `TLPIC_VEC_DMA + 8'(i - 17);
    end else begin
      return `TLPIC_VEC_SER0 + 8'(i - 21);
    end
  endfunction

  // Priority level of internal source i. Bits 4 and 0 of the second
  // priority register are never consulted.
  function automatic logic intPrioOf(input int i, input logic [7:0] pa,
                                     input logic [7:0] pb);
    int c;
    c = (i - 2) / 3;
    if (i < 2) begin
      return pa[3];
    end else if (i < 17) begin
      case (c)
        0: return pa[2];
        1: return pa[1];
        2: return pa[0];
        3: return pb[7];
        default: return pb[6];
      endcase
    end else if (i < 21) begin
      return pb[5];
    end else if (i < 25) begin
      return pb[3];
    end else if (i < 29) begin
      return pb[2];
    end else begin
      return pb[1];
    end
  endfunction

  // Priority level of pin n.
  function automatic logic pinPrioOf(input int n, input logic [7:0] pa);
    if (n < 2) begin
      return pa[7 - n];
    end else begin
      return pa[6 - n / 2];
    end
  endfunction

  tlpic_state_t st;
  tlpic_state_t next_st;
  logic [6:0] pinLvl;
  logic [5:0] lvlN;
  logic nmiLvl;
  logic [5:0] setEv;
  logic [5:0] clrExc;
  logic [5:0] clrSw;
  logic [5:0] pinRq;
  logic [29:0] intRq;
  logic nmiEdge;
  logic wbReq;
  logic wbDone;
  tlpic_rsel_t rsel;
  logic ue;
  logic acc1;
  logic acc0;
  logic have1;
  logic have0;
  logic [7:0] best1;
  logic [7:0] best0;

  // Pins pass the synchroniser whatever their port direction.
  tlpic_sync #(
    .W(7)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .raw({nmiPin, pinReqN}),
    .level(pinLvl)
  );

  assign lvlN = pinLvl[5:0];
  assign nmiLvl = pinLvl[6];

  always_comb begin
    wbReq = wb_cyc_i && wb_stb_i;
    wbDone = wbReq && st.ack;
    rsel = regSel(wb_adr_i);
    ue = st.sysCtl[`TLPIC_BIT_UE];
    // Rising or falling edge per the edge select bit.
    if (st.sysCtl[`TLPIC_BIT_NMI_EDGE_SELECT]) begin
      nmiEdge = nmiLvl && !st.nmiPrev;
    end else begin
      nmiEdge = !nmiLvl && st.nmiPrev;
    end
    for (int n = 0; n < 6; n++) begin
      if (st.senseSel[n]) begin
        setEv[n] = st.pinPrev[n] && !lvlN[n];
      end else begin
        setEv[n] = !lvlN[n];
      end
      clrExc[n] = excTaken && (excVec == `TLPIC_VEC_PIN0 + 8'(n))
                  && (st.senseSel[n] || lvlN[n]);
      clrSw[n] = wbDone && wb_we_i && wb_sel_i[0] && (rsel == TLPIC_RS_FLAG)
                 && !wb_dat_i[n] && st.armed[n];
    end
    pinRq = st.flags & st.pinEnable[5:0];
    intRq = intSrc & ~dmaSteer;
    // Masking of the two levels.
    acc0 = !iMask;
    acc1 = !iMask || (!ue && !uiMask);
    // Later assignments override, so the smallest vector wins.
    have1 = 1'b0;
    have0 = 1'b0;
    best1 = 8'h00;
    best0 = 8'h00;
    for (int i = 29; i >= 0; i--) begin
      if (intRq[i]) begin
        if (intPrioOf(i, st.prioFirst, st.prioSecond)) begin
          have1 = 1'b1;
          best1 = intVecOf(i);
        end else begin
          have0 = 1'b1;
          best0 = intVecOf(i);
        end
      end
    end
    for (int n = 5; n >= 0; n--) begin
      if (pinRq[n]) begin
        if (pinPrioOf(n, st.prioFirst)) begin
          have1 = 1'b1;
          best1 = `TLPIC_VEC_PIN0 + 8'(n);
        end else begin
          have0 = 1'b1;
          best0 = `TLPIC_VEC_PIN0 + 8'(n);
        end
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.pinPrev = lvlN;
    next_st.nmiPrev = nmiLvl;
    // A new event wins over a clear in the same cycle.
    next_st.flags = (st.flags & ~(clrExc | clrSw)) | setEv;
    next_st.nmiPend = (st.nmiPend && !(excTaken && excVec == `TLPIC_VEC_NMI))
                      || nmiEdge;
    if (st.nmiPend) begin
      next_st.intReq = 1'b1;
      next_st.intVec = `TLPIC_VEC_NMI;
    end else if (have1 && acc1) begin
      next_st.intReq = 1'b1;
      next_st.intVec = best1;
    end else if (have0 && acc0) begin
      next_st.intReq = 1'b1;
      next_st.intVec = best0;
    end else begin
      next_st.intReq = 1'b0;
      next_st.intVec = 8'h00;
    end
    next_st.wake = st.nmiPend || (|pinRq[`TLPIC_NWAKE-1:0]);
    // Bus slave: ack one cycle after the request, drop it the next.
    next_st.ack = wbReq && !st.ack;
    next_st.rdData = 8'h00;
    if (wbReq && !st.ack && !wb_we_i) begin
      case (rsel)
        TLPIC_RS_SYS: next_st.rdData = st.sysCtl;
        TLPIC_RS_SENSE: next_st.rdData = st.senseSel;
        TLPIC_RS_EN: next_st.rdData = st.pinEnable;
        TLPIC_RS_FLAG: next_st.rdData = {2'b00, st.flags};
        TLPIC_RS_PRIO1: next_st.rdData = st.prioFirst;
        TLPIC_RS_PRIO2: next_st.rdData = st.prioSecond;
        default: next_st.rdData = 8'h00;
      endcase
    end
    // A read of a set flag arms it for a clearing write.
    if (wbDone && !wb_we_i && rsel == TLPIC_RS_FLAG) begin
      next_st.armed = st.armed | st.flags;
    end
    next_st.armed = next_st.armed & ~clrSw;
    if (wbDone && wb_we_i && wb_sel_i[0]) begin
      case (rsel)
        TLPIC_RS_SYS: next_st.sysCtl = wb_dat_i[7:0];
        TLPIC_RS_SENSE: next_st.senseSel = wb_dat_i[7:0];
        TLPIC_RS_EN: next_st.pinEnable = wb_dat_i[7:0];
        TLPIC_RS_PRIO1: next_st.prioFirst = wb_dat_i[7:0];
        TLPIC_RS_PRIO2: next_st.prioSecond = wb_dat_i[7:0];
        default: next_st.sysCtl = st.sysCtl;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || hwStandby) begin
      st <= '0;
      st.sysCtl <= `TLPIC_RST_SYSCTL;
      st.prioSecond <= `TLPIC_RST_REG;
      st.pinPrev <= 6'h3f;
      st.nmiPrev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = {24'h000000, st.rdData};
  assign wb_ack_o = st.ack;
  assign intReq = st.intReq;
  assign intVec = st.intVec;
  assign wakeReq = st.wake;

  AST_PRIO2_STANDBY: assert property (@(posedge mclk) disable iff (rst)
    hwStandby |=> st.prioSecond == 8'h00)
    else $error("second priority not cleared by standby");

  AST_PIN_REGS_STANDBY: assert property (@(posedge mclk) disable iff (rst)
    hwStandby |=> st.flags == 6'h00 && st.pinEnable == 8'h00 && st.senseSel == 8'h00)
    else $error("pin registers not cleared by standby");

  AST_FLAG_RESV_ZERO: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o && !wb_we_i && regSel(wb_adr_i) == TLPIC_RS_FLAG |-> wb_dat_o[31:6] == 26'h0)
    else $error("flag register upper bits not zero");

  AST_NO_SET_BY_WRITE: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    ##1 (st.flags & ~$past(st.flags) & ~$past(setEv)) == 6'h00)
    else $error("flag set without a pin event");

  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    |setEv |=> (st.flags & $past(setEv)) == $past(setEv))
    else $error("pin event did not set its flag");

  AST_NMI_WINS: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    st.nmiPend |=> intReq && intVec == 8'h07)
    else $error("nonmaskable request not presented with vector 7");

  AST_UE1_BLOCK: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    ue && iMask && !st.nmiPend |=> !intReq)
    else $error("maskable request passed a set global mask");

  AST_UE0_BLOCK: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    !ue && iMask && uiMask && !st.nmiPend |=> !intReq)
    else $error("request passed with both masks set");

  AST_WAKE_PINS: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    !st.nmiPend && pinRq[2:0] == 3'b000 |=> !wakeReq)
    else $error("wake-up raised by a pin that may not wake");

  AST_ACK_ONE: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  AST_EDGE_EXC_CLEAR: assert property (@(posedge mclk) disable iff (rst || hwStandby)
    excTaken && excVec == `TLPIC_VEC_PIN0 && st.senseSel[0] && !setEv[0] |=> !st.flags[0])
    else $error("edge mode flag not cleared by its exception");

endmodule

`default_nettype wire

// File: tlpic_defs.svh
`ifndef TLPIC_DEFS_SVH
`define TLPIC_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define TLPIC_OFS_SYSCTL 8'h00
`define TLPIC_OFS_SENSE 8'h04
`define TLPIC_OFS_ENABLE 8'h08
`define TLPIC_OFS_FLAGS 8'h0c
`define TLPIC_OFS_PRIO1 8'h10
`define TLPIC_OFS_PRIO2 8'h14

// Reset values.
`define TLPIC_RST_SYSCTL 8'h0b
`define TLPIC_RST_REG 8'h00
`define TLPIC_RST_PINLVL 7'h7f

// Field positions in the system control register.
`define TLPIC_BIT_UE 3
`define TLPIC_BIT_NMI_EDGE_SELECT 2

// Vector numbers.
`define TLPIC_VEC_NMI 8'h07
`define TLPIC_VEC_PIN0 8'h0c
`define TLPIC_VEC_WDT 8'h14
`define TLPIC_VEC_TMR0 8'h18
`define TLPIC_VEC_DMA 8'h2c
`define TLPIC_VEC_SER0 8'h34

// Pins and internal sources.
`define TLPIC_NPINS 6
`define TLPIC_NINT 30
`define TLPIC_NWAKE 3

`endif

// File: tlpic_pkg.sv
`default_nettype none

package tlpic_pkg;

  typedef enum logic [2:0] {
    TLPIC_RS_SYS = 3'b000,
    TLPIC_RS_SENSE = 3'b001,
    TLPIC_RS_EN = 3'b010,
    TLPIC_RS_FLAG = 3'b011,
    TLPIC_RS_PRIO1 = 3'b100,
    TLPIC_RS_PRIO2 = 3'b101,
    TLPIC_RS_NONE = 3'b111
  } tlpic_rsel_t;

  typedef struct packed {
    logic [7:0] sysCtl;
    logic [7:0] senseSel;
    logic [7:0] pinEnable;
    logic [7:0] prioFirst;
    logic [7:0] prioSecond;
    logic [5:0] flags;
    logic [5:0] armed;
    logic [5:0] pinPrev;
    logic nmiPrev;
    logic nmiPend;
    logic ack;
    logic [7:0] rdData;
    logic intReq;
    logic [7:0] intVec;
    logic wake;
  } tlpic_state_t;

endpackage

`default_nettype wire

// File: tlpic_sync.sv
`timescale 1ns/100ps
`default_nettype none

`include "tlpic_defs.svh"

module tlpic_sync #(
  parameter int W = 7
) (
  input wire logic mclk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic [W-1:0] raw, // Asynchronous pin levels.
  output logic [W-1:0] level // Filtered levels.
);

  if (W < 1 || W > 7) begin : g_chk
    $error("tlpic_sync: W must be 1 to 7");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } tlpic_sync_st_t;

  tlpic_sync_st_t st;
  tlpic_sync_st_t next_st;

  // A level is accepted only once the second and third stages agree.
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st.s1 <= W'(`TLPIC_RST_PINLVL);
      st.s2 <= W'(`TLPIC_RST_PINLVL);
      st.s3 <= W'(`TLPIC_RST_PINLVL);
      st.lvl <= W'(`TLPIC_RST_PINLVL);
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;

endmodule

`default_nettype wire
